// ===== hdl/baud_link_if.sv
// link between register block and tick generator
`timescale 1ns/1ps
interface baud_link_if;
  logic                      ce;
  logic                      run;
  logic [baud_pkg::DIV_W-1:0] divisor;
  logic                      sample_tick;
  logic                      bit_tick;

  modport gen (input ce, input run, input divisor, output sample_tick, output bit_tick);
  modport ctl (output ce, output run, output divisor, input sample_tick, input bit_tick);
endinterface : baud_link_if

// ===== hdl/baud_pkg.sv
// constants, field positions and types of the baud rate generator
package baud_pkg;

  // bus geometry
  localparam int unsigned WB_AW   = 8;
  localparam int unsigned WB_DW   = 32;
  localparam int unsigned WB_SW   = 4;

  // divisor geometry
  localparam int unsigned DIV_W   = 13;
  localparam int unsigned HI_W    = 5;
  localparam int unsigned LO_W    = 8;
  localparam int unsigned OS_W    = 4;
  localparam logic [OS_W-1:0] OS_LAST = 4'hf;

  // register byte offsets
  localparam int unsigned NUM_REGS = 5;
  localparam logic [WB_AW-1:0] HIGH_OFF = 8'h00;
  localparam logic [WB_AW-1:0] LOW_OFF  = 8'h04;
  localparam logic [WB_AW-1:0] CTRL_OFF = 8'h08;
  localparam logic [WB_AW-1:0] STAT_OFF = 8'h0c;
  localparam logic [WB_AW-1:0] MASK_OFF = 8'h10;

  // decode positions
  localparam int unsigned HIT_HIGH = 0;
  localparam int unsigned HIT_LOW  = 1;
  localparam int unsigned HIT_CTRL = 2;
  localparam int unsigned HIT_STAT = 3;
  localparam int unsigned HIT_MASK = 4;

  // high register fields
  localparam int unsigned HI_LBK_EN_BIT  = 7;
  localparam int unsigned HI_EDGE_EN_BIT = 6;
  localparam int unsigned HI_DIV_MSB     = 4;

  // control register fields
  localparam int unsigned CTRL_RX_ON_BIT = 0;
  localparam int unsigned CTRL_TX_ON_BIT = 1;

  // event bits in status and mask
  localparam int unsigned NUM_EVENTS    = 3;
  localparam int unsigned EV_LBK_BIT    = 0;
  localparam int unsigned EV_EDGE_BIT   = 1;
  localparam int unsigned EV_LOAD_BIT   = 2;

  // reset values
  localparam logic [LO_W-1:0]       HIGH_RESET = 8'h00;
  localparam logic [LO_W-1:0]       LOW_RESET  = 8'h04;
  localparam logic [1:0]            CTRL_RESET = 2'h0;
  localparam logic [NUM_EVENTS-1:0] STAT_RESET = 3'h0;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET = 3'h7;

  // generator states
  typedef enum logic [2:0] {
    GEN_WAIT = 3'b001,
    GEN_OFF  = 3'b010,
    GEN_RUN  = 3'b100
  } gen_state_t;

endpackage : baud_pkg

// ===== hdl/baud_tick_gen.sv
// prescaler producing sixteen-times and bit-rate ticks
`timescale 1ns/1ps
module baud_tick_gen (
  // clock and reset
  input wire logic  clk_i,
  input wire logic  rst_i,
  // link to register block
  baud_link_if.gen  lnk
);
  import baud_pkg::*;

  logic [DIV_W-1:0] pre;
  logic [OS_W-1:0]  os;
  logic             wrap;

  assign wrap = lnk.run && (pre == '0);

  // divide by divisor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= '0;
    end else if (lnk.ce) begin
      if (!lnk.run) begin
        pre <= '0;
      end else if (pre == '0) begin
        pre <= lnk.divisor - 13'h0001;
      end else begin
        pre <= pre - 13'h0001;
      end
    end
  end

  // divide by sixteen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      os <= '0;
    end else if (lnk.ce) begin
      if (!lnk.run) begin
        os <= '0;
      end else if (wrap) begin
        os <= os + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lnk.sample_tick <= 1'b0;
      lnk.bit_tick    <= 1'b0;
    end else if (lnk.ce) begin
      lnk.sample_tick <= wrap;
      lnk.bit_tick    <= wrap && (os == OS_LAST);
    end
  end
endmodule : baud_tick_gen

// ===== hdl/event_irq.sv
// sticky event status with mask and gate onto one interrupt
`timescale 1ns/1ps
module event_irq (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  // events and software clear
  input  wire logic [baud_pkg::NUM_EVENTS-1:0]     set_i,
  input  wire logic [baud_pkg::NUM_EVENTS-1:0]     clear_i,
  // gating
  input  wire logic [baud_pkg::NUM_EVENTS-1:0]     mask_i,
  input  wire logic [baud_pkg::NUM_EVENTS-1:0]     gate_i,
  // results
  output logic      [baud_pkg::NUM_EVENTS-1:0]     status_o,
  output logic                                     irq_o
);
  import baud_pkg::*;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= STAT_RESET;
    end else if (ce_i) begin
      status_o <= (status_o & ~clear_i) | set_i;
    end
  end

  assign irq_o = |(status_o & mask_i & gate_i);
endmodule : event_irq

// ===== hdl/serial_baud_rate_generator.sv
// baud rate generator with divisor registers and interrupt enables
// What this block does
// - divisor is high register bits 4..0 above low register bits 7..0.
// - high write only buffers; low write applies buffered high plus new low.
// - divisor zero holds the generator still, no ticks at all.
// - low register resets nonzero; generator idle until receiver or transmitter enabled.
// - high bit 7 lets the line break flag raise an interrupt.
// - high bit 6 lets the receive edge flag raise an interrupt.
`timescale 1ns/1ps
module serial_baud_rate_generator (
  // clock, reset, enable
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RESET_I,
  input  wire logic                         CE_I,
  // wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [baud_pkg::WB_AW-1:0]   WB_ADR_I,
  input  wire logic [baud_pkg::WB_SW-1:0]   WB_SEL_I,
  input  wire logic [baud_pkg::WB_DW-1:0]   WB_DAT_I,
  output logic      [baud_pkg::WB_DW-1:0]   WB_DAT_O,
  output logic                              WB_ACK_O,
  // receiver events
  input  wire logic                         LINE_BREAK_I,
  input  wire logic                         RX_EDGE_I,
  // generator outputs
  output logic                              SAMPLE_TICK_O,
  output logic                              BIT_TICK_O,
  output logic                              BAUD_ACTIVE_O,
  output logic                              RX_ON_O,
  output logic                              TX_ON_O,
  // interrupt
  output logic                              IRQ_O
);
  import baud_pkg::*;

  function automatic logic [NUM_REGS-1:0] reg_hit(input logic [WB_AW-1:0] adr);
    logic [NUM_REGS-1:0] h;
    h           = '0;
    h[HIT_HIGH] = (adr[WB_AW-1:2] == HIGH_OFF[WB_AW-1:2]);
    h[HIT_LOW]  = (adr[WB_AW-1:2] == LOW_OFF[WB_AW-1:2]);
    h[HIT_CTRL] = (adr[WB_AW-1:2] == CTRL_OFF[WB_AW-1:2]);
    h[HIT_STAT] = (adr[WB_AW-1:2] == STAT_OFF[WB_AW-1:2]);
    h[HIT_MASK] = (adr[WB_AW-1:2] == MASK_OFF[WB_AW-1:2]);
    return h;
  endfunction : reg_hit

  baud_link_if lnk ();

  logic                  access;
  logic                  wr;
  logic [NUM_REGS-1:0]   hit;
  logic                  wr_high;
  logic                  wr_low;
  logic                  wr_ctrl;
  logic                  wr_stat;
  logic                  wr_mask;
  logic                  lbk_en;
  logic                  edge_en;
  logic [HI_W-1:0]       hi_buf;
  logic [HI_W-1:0]       hi_work;
  logic [LO_W-1:0]       lo_work;
  logic [1:0]            ctrl;
  logic [NUM_EVENTS-1:0] mask;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_gate;
  logic [NUM_EVENTS-1:0] ev_clear;
  logic [WB_DW-1:0]      next_rdata;
  logic                  enable_write;
  gen_state_t            state;
  gen_state_t            next_state;

  // bus decode, one access per request
  assign access  = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I;
  assign wr      = access && WB_WE_I && WB_SEL_I[0];
  assign hit     = reg_hit(WB_ADR_I);
  assign wr_high = wr && hit[HIT_HIGH];
  assign wr_low  = wr && hit[HIT_LOW];
  assign wr_ctrl = wr && hit[HIT_CTRL];
  assign wr_stat = wr && hit[HIT_STAT];
  assign wr_mask = wr && hit[HIT_MASK];
  assign enable_write = wr_ctrl && (WB_DAT_I[CTRL_RX_ON_BIT] || WB_DAT_I[CTRL_TX_ON_BIT]);

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      WB_ACK_O <= 1'b0;
    end else if (CE_I) begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      lbk_en  <= HIGH_RESET[HI_LBK_EN_BIT];
      edge_en <= HIGH_RESET[HI_EDGE_EN_BIT];
      hi_buf  <= HIGH_RESET[HI_DIV_MSB:0];
    end else if (wr_high) begin
      lbk_en  <= WB_DAT_I[HI_LBK_EN_BIT];
      edge_en <= WB_DAT_I[HI_EDGE_EN_BIT];
      hi_buf  <= WB_DAT_I[HI_DIV_MSB:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      hi_work <= HIGH_RESET[HI_DIV_MSB:0];
      lo_work <= LOW_RESET;
    end else if (wr_low) begin
      hi_work <= hi_buf;
      lo_work <= WB_DAT_I[LO_W-1:0];
    end
  end

  assign lnk.divisor = {hi_work, lo_work};
  assign lnk.ce      = CE_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {WB_DAT_I[CTRL_TX_ON_BIT], WB_DAT_I[CTRL_RX_ON_BIT]};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= WB_DAT_I[NUM_EVENTS-1:0];
    end
  end

  // waits for first enable; zero divisor stops
  always_comb begin
    next_state = state;
    unique case (state)
      GEN_WAIT: begin
        if (enable_write) begin
          next_state = GEN_OFF;
        end
      end
      GEN_OFF: begin
        if (lnk.divisor != '0) begin
          next_state = GEN_RUN;
        end
      end
      GEN_RUN: begin
        if (lnk.divisor == '0) begin
          next_state = GEN_OFF;
        end
      end
      default: begin
        next_state = GEN_WAIT;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state <= GEN_WAIT;
    end else if (CE_I) begin
      state <= next_state;
    end
  end

  assign lnk.run = (state == GEN_RUN) && (lnk.divisor != '0);

  baud_tick_gen u_tick (
    .clk_i (SYS_CLK_I),
    .rst_i (RESET_I),
    .lnk   (lnk.gen)
  );

  assign ev_set   = {wr_low, RX_EDGE_I && CE_I, LINE_BREAK_I && CE_I};
  assign ev_clear = wr_stat ? WB_DAT_I[NUM_EVENTS-1:0] : '0;
  assign ev_gate  = {1'b1, edge_en, lbk_en};

  event_irq u_irq (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RESET_I),
    .ce_i     (CE_I),
    .set_i    (ev_set),
    .clear_i  (ev_clear),
    .mask_i   (mask),
    .gate_i   (ev_gate),
    .status_o (status),
    .irq_o    (IRQ_O)
  );

  // bit 5 of high reads zero
  always_comb begin
    next_rdata = '0;
    unique case (1'b1)
      hit[HIT_HIGH]: next_rdata[LO_W-1:0] = {lbk_en, edge_en, 1'b0, hi_buf};
      hit[HIT_LOW]:  next_rdata[LO_W-1:0] = lo_work;
      hit[HIT_CTRL]: next_rdata[1:0] = ctrl;
      hit[HIT_STAT]: next_rdata[NUM_EVENTS-1:0] = status;
      hit[HIT_MASK]: next_rdata[NUM_EVENTS-1:0] = mask;
      default:       next_rdata = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      WB_DAT_O <= '0;
    end else if (access && !WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end

  assign SAMPLE_TICK_O = lnk.sample_tick;
  assign BIT_TICK_O    = lnk.bit_tick;
  assign BAUD_ACTIVE_O = lnk.run;
  assign RX_ON_O       = ctrl[CTRL_RX_ON_BIT];
  assign TX_ON_O       = ctrl[CTRL_TX_ON_BIT];

  // helper: cycles between sample ticks at steady divisor
  logic [DIV_W-1:0] gap;
  logic [DIV_W-1:0] div_prev;
  logic             steady;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      gap      <= '0;
      div_prev <= '0;
      steady   <= 1'b0;
    end else if (CE_I) begin
      div_prev <= lnk.divisor;
      gap      <= SAMPLE_TICK_O ? 13'h0001 : gap + 13'h0001;
      if ((lnk.divisor != div_prev) || !lnk.run) begin
        steady <= 1'b0;
      end else if (SAMPLE_TICK_O) begin
        steady <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  property p_div_fields;
    wr_low |=> lnk.divisor[LO_W-1:0] == $past(WB_DAT_I[LO_W-1:0]) && lnk.divisor[DIV_W-1:LO_W] == $past(hi_buf);
  endproperty
  a_div_fields: assert property (p_div_fields) else $error("divisor halves not joined");

  property p_high_buffered;
    wr_high |=> $stable(lnk.divisor);
  endproperty
  a_high_buffered: assert property (p_high_buffered) else $error("high write changed divisor");

  property p_zero_quiet;
    (lnk.divisor == 13'h0000) ##1 (lnk.divisor == 13'h0000) |-> !SAMPLE_TICK_O && !BAUD_ACTIVE_O;
  endproperty
  a_zero_quiet: assert property (p_zero_quiet) else $error("generator ticks at divisor zero");

  property p_tick_period;
    SAMPLE_TICK_O && CE_I && steady && (lnk.divisor == div_prev) |-> gap == lnk.divisor;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample tick spacing wrong");

  property p_bit_sixteenth;
    BIT_TICK_O |-> SAMPLE_TICK_O;
  endproperty
  a_bit_sixteenth: assert property (p_bit_sixteenth) else $error("bit tick without sample tick");

  property p_idle_until_enabled;
    (state == GEN_WAIT) |-> !BAUD_ACTIVE_O ##1 !SAMPLE_TICK_O;
  endproperty
  a_idle_until_enabled: assert property (p_idle_until_enabled) else $error("generator ran before enable");

  property p_low_nonzero_reset;
    $fell(RESET_I) |-> lo_work != 8'h00 && state == GEN_WAIT;
  endproperty
  a_low_nonzero_reset: assert property (p_low_nonzero_reset) else $error("low register reset value zero");

  property p_break_irq;
    status[EV_LBK_BIT] && lbk_en && mask[EV_LBK_BIT] |-> IRQ_O;
  endproperty
  a_break_irq: assert property (p_break_irq) else $error("break interrupt missing");

  property p_break_sticky;
    LINE_BREAK_I && CE_I |=> status[EV_LBK_BIT];
  endproperty
  a_break_sticky: assert property (p_break_sticky) else $error("break flag lost");

  property p_edge_irq;
    !edge_en && !lbk_en && !status[EV_LOAD_BIT] |-> !IRQ_O;
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt while disabled");

  property p_unused_zero;
    WB_ACK_O && $past(hit[HIT_HIGH] && !WB_WE_I) |-> !WB_DAT_O[5];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused high bit read as one");

  c_low_write: cover property (wr_low ##1 BAUD_ACTIVE_O);
  c_bit_tick:  cover property (BIT_TICK_O);
  c_irq:       cover property ($rose(IRQ_O));
  c_stop:      cover property (BAUD_ACTIVE_O ##1 !BAUD_ACTIVE_O);
endmodule : serial_baud_rate_generator

// ===== tb/rx_node_model.sv
// remote serial node model: receiver events and tick counting
`timescale 1ns/1ps
module rx_node_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // requests from bench
  input  wire logic        brk_req_i,
  input  wire logic        edge_req_i,
  // generator side
  input  wire logic        sample_tick_i,
  output logic             line_break_o,
  output logic             rx_edge_o,
  output logic [15:0]      ticks_o
);
  always_ff @(posedge clk_i) begin
    line_break_o <= brk_req_i & ~rst_i;
    rx_edge_o    <= edge_req_i & ~rst_i;
  end

  // ticks seen on the line side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ticks_o <= 16'h0;
    end else if (sample_tick_i) begin
      ticks_o <= ticks_o + 16'h1;
    end
  end
endmodule : rx_node_model

// ===== tb/test_serial_baud_rate_generator.sv
// self-checking bench of the baud rate generator
`timescale 1ns/1ps
module test_serial_baud_rate_generator;
  import baud_pkg::*;
  logic             clk, rst, ce, cyc, stb, we, brk_req, edge_req;
  logic [WB_AW-1:0] adr;
  logic [WB_SW-1:0] sel;
  logic [WB_DW-1:0] wdat, dat_o, rdat;
  logic             ack, stick, btick, active, rx_on, tx_on, irq, lbk, edg;
  logic [15:0]      ticks;
  int               error_cnt, n_tests;

  serial_baud_rate_generator i_dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .LINE_BREAK_I(lbk), .RX_EDGE_I(edg), .SAMPLE_TICK_O(stick),
    .BIT_TICK_O(btick), .BAUD_ACTIVE_O(active), .RX_ON_O(rx_on), .TX_ON_O(tx_on), .IRQ_O(irq));

  rx_node_model i_node (
    .clk_i(clk), .rst_i(rst), .brk_req_i(brk_req), .edge_req_i(edge_req),
    .sample_tick_i(stick), .line_break_o(lbk), .rx_edge_o(edg), .ticks_o(ticks));

  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // classic cycle, held until ack, one idle cycle after
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    sel  <= 4'hf;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    rdat = dat_o;
    if (t >= 20) chk("ack", 1, 0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    wb(1'b0, a, 8'h0);
    chk(name, exp, rdat);
  endtask : rd

  // cycles between two ticks, second interval checked
  task automatic period(input logic bitl, input int exp, input string name);
    int n;
    int t;
    repeat (2) begin
      t = 0;
      while ((bitl ? btick : stick) !== 1'b1 && t < 20000) begin
        @(posedge clk);
        t++;
      end
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((bitl ? btick : stick) !== 1'b1 && n < 20000);
    end
    chk(name, exp, n);
  endtask : period

  task automatic quiet(input string name);
    logic [15:0] t0;
    t0 = ticks;
    repeat (64) @(posedge clk);
    chk(name, {16'h0, t0}, {16'h0, ticks});
    chk("active", 0, active);
  endtask : quiet

  function automatic int divisor(input logic [7:0] h, input logic [7:0] l);
    return int'({h[4:0], l});
  endfunction : divisor

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    logic [7:0] hi, nh, lo, en, other, ev;
    logic [2:0] snap;
    error_cnt = 0;
    n_tests = 0;
    rst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    brk_req = 1'b0;
    edge_req = 1'b0;
    void'($urandom(32'ha35a7476));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(HIGH_OFF, 32'h0, "high");
    rd(LOW_OFF, 32'h4, "low");
    rd(CTRL_OFF, 32'h0, "ctrl");
    rd(STAT_OFF, 32'h0, "status");
    rd(MASK_OFF, 32'h7, "mask");
    rd(8'h14, 32'h0, "unmapped");
    quiet("idle ticks");
    wb(1'b1, CTRL_OFF, 8'h02);
    chk("tx_on", 1, tx_on);
    period(1'b0, 4, "sample period");
    chk("active", 1, active);
    period(1'b1, 64, "bit period");
    // enable low freezes the tick outputs
    ce <= 1'b0;
    @(posedge clk);
    snap = {stick, btick, active};
    repeat (20) @(posedge clk);
    chk("frozen ticks", {29'h0, snap}, {29'h0, stick, btick, active});
    ce <= 1'b1;
    period(1'b0, 4, "sample period");
    wb(1'b1, CTRL_OFF, 8'h01);
    chk("rx_on", 1, rx_on);
    chk("tx_on", 0, tx_on);
    chk("active", 1, active);
    wb(1'b1, HIGH_OFF, 8'h00);
    wb(1'b1, LOW_OFF, 8'h01);
    period(1'b0, 1, "sample period");
    period(1'b1, 16, "bit period");
    chk("irq", 1, irq);
    rd(STAT_OFF, 32'h4, "load flag");
    wb(1'b1, STAT_OFF, 8'h07);
    chk("irq", 0, irq);
    hi = 8'h00;
    lo = 8'h01;
    repeat (3) begin
      nh = ($urandom & 8'he0) | {7'h0, ~hi[0]};
      wb(1'b1, HIGH_OFF, nh);
      rd(HIGH_OFF, {24'h0, nh & 8'hdf}, "high");
      period(1'b0, divisor(hi, lo), "held period");
      lo = 8'($urandom_range(255, 1));
      hi = nh;
      wb(1'b1, LOW_OFF, lo);
      rd(LOW_OFF, {24'h0, lo}, "low");
      period(1'b0, divisor(hi, lo), "new period");
    end
    wb(1'b1, HIGH_OFF, 8'h00);
    wb(1'b1, LOW_OFF, 8'h00);
    quiet("zero divisor");
    for (int i = 0; i < 2; i++) begin
      en = i ? 8'h40 : 8'h80;
      other = i ? 8'h80 : 8'h40;
      ev = i ? 8'h02 : 8'h01;
      wb(1'b1, STAT_OFF, 8'h07);
      wb(1'b1, HIGH_OFF, en);
      chk("irq", 0, irq);
      brk_req <= ~en[6];
      edge_req <= en[6];
      @(posedge clk);
      brk_req <= 1'b0;
      edge_req <= 1'b0;
      repeat (3) @(posedge clk);
      rd(STAT_OFF, {24'h0, ev}, "status");
      chk("irq", 1, irq);
      wb(1'b1, MASK_OFF, ~ev & 8'h07);
      chk("irq", 0, irq);
      wb(1'b1, MASK_OFF, 8'h07);
      wb(1'b1, HIGH_OFF, other);
      chk("irq", 0, irq);
      wb(1'b1, HIGH_OFF, en);
      chk("irq", 1, irq);
      wb(1'b1, STAT_OFF, ev);
      rd(STAT_OFF, 32'h0, "status");
      chk("irq", 0, irq);
    end
    // reset while stopped at divisor zero returns to idle
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(LOW_OFF, 32'h4, "low after reset");
    rd(CTRL_OFF, 32'h0, "ctrl after reset");
    quiet("idle after reset");
    give_verdict();
  end
endmodule : test_serial_baud_rate_generator
